// [scc_pkg.sv]
// scc_pkg: register map, field positions, reset values and timing
// constants of the system clock controller.
// assumes an 8-bit register port and a 100 MHz controller clock.

package scc_pkg;

  // ==========================================================
  // register port geometry
  localparam int SCC_AW = 4;
  localparam int SCC_DW = 8;

  // ==========================================================
  // register offsets
  localparam logic [3:0] SCC_REG_SYS_SRC = 4'h0;
  localparam logic [3:0] SCC_REG_SYS_DIV = 4'h1;
  localparam logic [3:0] SCC_REG_GATE = 4'h2;
  localparam logic [3:0] SCC_REG_PERIPH = 4'h3;
  localparam logic [3:0] SCC_REG_RTC_SRC = 4'h4;
  localparam logic [3:0] SCC_REG_SUPERV = 4'h5;
  localparam logic [3:0] SCC_REG_PIN_OUT = 4'h6;
  localparam logic [3:0] SCC_REG_OSC_CFG = 4'h7;
  localparam logic [3:0] SCC_REG_IRQ_STAT = 4'h8;
  localparam logic [3:0] SCC_REG_IRQ_MASK = 4'h9;
  localparam logic [3:0] SCC_REG_SW_STAT = 4'ha;

  // ==========================================================
  // oscillator source codes (system, rtc)
  localparam logic [1:0] SCC_SRC_INT_FAST = 2'h0;
  localparam logic [1:0] SCC_SRC_EXT_FAST = 2'h1;
  localparam logic [1:0] SCC_SRC_EXT_SLOW = 2'h2;
  localparam logic [1:0] SCC_SRC_INT_SLOW = 2'h3;

  // clock pin output source codes
  localparam logic [1:0] SCC_PIN_SYS = 2'h0;
  localparam logic [1:0] SCC_PIN_RTC = 2'h1;
  localparam logic [1:0] SCC_PIN_INT_FAST = 2'h2;
  localparam logic [1:0] SCC_PIN_EXT_FAST = 2'h3;

  // ==========================================================
  // field positions
  localparam int SCC_GATE_CORE = 0;
  localparam int SCC_GATE_MEM = 1;
  localparam int SCC_SV_EN = 0;
  localparam int SCC_SV_FAIL = 1;
  localparam int SCC_PIN_EN = 2;
  localparam int SCC_PIN_DIV_LSB = 3;
  localparam int SCC_OSC_EF_EN = 0;
  localparam int SCC_OSC_EF_BYP = 1;
  localparam int SCC_OSC_ES_EN = 2;
  localparam int SCC_OSC_ES_BYP = 3;
  localparam int SCC_IRQ_FAIL = 0;
  localparam int SCC_IRQ_SWITCH = 1;
  localparam int SCC_SW_BUSY = 2;

  // ==========================================================
  // reset values
  localparam logic [1:0] SCC_RST_SYS_SRC = SCC_SRC_INT_FAST;
  localparam logic [2:0] SCC_RST_SYS_DIV = 3'h3;
  localparam logic [1:0] SCC_RST_GATE = 2'h3;
  localparam logic [7:0] SCC_RST_PERIPH = 8'hff;
  localparam logic [1:0] SCC_RST_RTC_SRC = SCC_SRC_INT_SLOW;
  localparam logic [5:0] SCC_RST_PIN_OUT = 6'h00;
  localparam logic [3:0] SCC_RST_OSC_CFG = 4'h0;
  localparam logic [1:0] SCC_RST_IRQ_MASK = 2'h0;

  // ==========================================================
  // timing: silence on the external fast input that counts as failure
  localparam int SCC_CLK_PERIOD_NS = 10;
  localparam int SCC_FAIL_TIMEOUT_NS = 4000;
  localparam int SCC_FAIL_TIMEOUT_CYC = SCC_FAIL_TIMEOUT_NS / SCC_CLK_PERIOD_NS;

  // ==========================================================
  // source switch sequencer
  typedef enum logic [1:0] {SCC_SW_IDLE, SCC_SW_OLD_LOW, SCC_SW_NEW_LOW} scc_sw_e;

endpackage

// [scc_clk_div.sv]
// scc_clk_div: divides a sampled clock level by a power of two.
// assumes src_i is sampled by clock_i and well below half its rate.

`timescale 1ns/1ps

module scc_clk_div
  import scc_pkg::*;
#(
  parameter int CW = 7
)(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // source and ratio, divide by 2**code_i
  input wire logic src_i,
  input wire logic [2:0] code_i,
  // divided level
  output logic clk_o
);

  logic src_q;
  logic [CW-1:0] cnt;
  logic next_src_q;
  logic [CW-1:0] next_cnt;
  logic next_clk;
  logic [CW-1:0] half_m1;

  // ==========================================================
  // edge counter: toggles after 2**(code-1) rising edges
  always_comb
  begin
    half_m1 = CW'((CW'(1) << (code_i - 3'h1)) - CW'(1));
    next_src_q = src_i;
    next_cnt = cnt;
    next_clk = clk_o;
    if (code_i == 3'h0)
    begin
      next_clk = src_i;
      next_cnt = '0;
    end
    else if (src_i && !src_q)
    begin
      // >= keeps a ratio change mid-count from running away
      if (cnt >= half_m1)
      begin
        next_cnt = '0;
        next_clk = ~clk_o;
      end
      else
        next_cnt = cnt + CW'(1);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      src_q <= 1'b0;
      cnt <= '0;
      clk_o <= 1'b0;
    end
    else
    begin
      src_q <= next_src_q;
      cnt <= next_cnt;
      clk_o <= next_clk;
    end
  end

endmodule // scc_clk_div

// [scc_edge_watch.sv]
// scc_edge_watch: flags a clock level that stops toggling.
// assumes level_i is sampled by clock_i; arm_i low clears the count.

`timescale 1ns/1ps

module scc_edge_watch
  import scc_pkg::*;
#(
  parameter int TIMEOUT_CYC = SCC_FAIL_TIMEOUT_CYC,
  parameter int CW = $clog2(TIMEOUT_CYC + 1)
)(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // watched level
  input wire logic arm_i,
  input wire logic level_i,
  // one-cycle pulse on timeout
  output logic fail_o
);

  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYC - 1);

  logic lvl_q;
  logic [CW-1:0] cnt;
  logic next_lvl_q;
  logic [CW-1:0] next_cnt;
  logic next_fail;

  // ==========================================================
  // silence counter; parks at LAST so the pulse fires once
  always_comb
  begin
    next_lvl_q = level_i;
    next_cnt = cnt;
    next_fail = 1'b0;
    if (!arm_i || level_i != lvl_q)
      next_cnt = '0;
    else if (cnt != LAST)
    begin
      next_cnt = cnt + CW'(1);
      next_fail = (cnt == LAST - CW'(1));
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      lvl_q <= 1'b0;
      cnt <= '0;
      fail_o <= 1'b0;
    end
    else
    begin
      lvl_q <= next_lvl_q;
      cnt <= next_cnt;
      fail_o <= next_fail;
    end
  end

endmodule // scc_edge_watch

// [scc_clock_ctrl.sv]
// scc_clock_ctrl: system clock controller top.
// assumes oscillator levels synchronous to clock_i,
// and power-state inputs driven as levels.
// Behaviour
// - out of reset the system clock is the internal fast oscillator divided by eight.
// - the system source is one of external fast, internal fast, external slow, internal slow.
// - a source change while running gives no glitch and no lost clocking.
// - core and peripheral clocks pass through a software-set divider.
// - core, each peripheral and memory clocks can be stopped one by one.
// - the rtc clock picks any of the four sources, independent of the system source.
// - with supervision on, a failed external fast clock moves the system to the internal fast one.
// - a selectable internal clock can be driven onto a pin.
// - each external oscillator runs as resonator driver or in bypass.
// - wait stops the core clock, selected peripherals keep running.
// - active-halt stops core and peripheral clocks, rtc keeps running.
//
// Design decisions made here: the register offsets and the strobed register port.

`timescale 1ns/1ps

module scc_clock_ctrl
  import scc_pkg::*;
#(
  parameter int NP = 8,
  parameter int FAIL_TIMEOUT_CYC = SCC_FAIL_TIMEOUT_CYC
)(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [SCC_AW-1:0] reg_addr_i,
  input wire logic [SCC_DW-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [SCC_DW-1:0] reg_rdata_o,
  // oscillator levels
  input wire logic ext_fast_osc_i,
  input wire logic int_fast_osc_i,
  input wire logic ext_slow_osc_i,
  input wire logic int_slow_osc_i,
  // oscillator control
  output logic ext_fast_osc_en_o,
  output logic ext_fast_osc_bypass_o,
  output logic ext_slow_osc_en_o,
  output logic ext_slow_osc_bypass_o,
  // power states
  input wire logic wait_mode_i,
  input wire logic active_halt_i,
  // distributed clocks
  output logic main_system_clock_o,
  output logic core_clk_o,
  output logic mem_clk_o,
  output logic [NP-1:0] periph_clk_o,
  output logic rtc_clk_o,
  output logic clock_pin_output_o,
  // interrupt
  output logic irq_o
);

  // ==========================================================
  // state
  scc_sw_e st, next_st;
  logic [1:0] sys_tgt, next_sys_tgt;
  logic [1:0] sys_cur, next_sys_cur;
  logic [2:0] div_code, next_div_code;
  logic [1:0] gate, next_gate;
  logic [NP-1:0] periph, next_periph;
  logic [1:0] rtc_src, next_rtc_src;
  logic sv_en, next_sv_en;
  logic sv_fail, next_sv_fail;
  logic [5:0] pin_cfg, next_pin_cfg;
  logic [3:0] osc_cfg, next_osc_cfg;
  logic [1:0] irq_stat, next_irq_stat;
  logic [1:0] irq_mask, next_irq_mask;
  logic [SCC_DW-1:0] next_rdata;
  logic next_irq;
  logic mux_q, next_mux;
  logic core_en, next_core_en;
  logic mem_en, next_mem_en;
  logic [NP-1:0] per_en, next_per_en;
  logic [3:0] osc_lvl;
  logic sys_div;
  logic pin_lvl;
  logic pin_div;
  logic fail_evt;
  logic arm;

  // codes 0..3 index this vector
  assign osc_lvl = {int_slow_osc_i, ext_slow_osc_i, ext_fast_osc_i, int_fast_osc_i};

  // ==========================================================
  // external fast clock supervision
  // armed only while that clock is in use or being switched to
  assign arm = sv_en && (sys_cur == SCC_SRC_EXT_FAST || sys_tgt == SCC_SRC_EXT_FAST);

  scc_edge_watch #(
    .TIMEOUT_CYC(FAIL_TIMEOUT_CYC)
  ) u_watch (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .arm_i(arm),
    .level_i(ext_fast_osc_i),
    .fail_o(fail_evt)
  );

  // ==========================================================
  // prescalers: system and clock pin
  scc_clk_div u_sys_div (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .src_i(mux_q),
    .code_i(div_code),
    .clk_o(sys_div)
  );

  always_comb
  begin
    unique case (pin_cfg[1:0])
      SCC_PIN_SYS: pin_lvl = sys_div;
      SCC_PIN_RTC: pin_lvl = rtc_clk_o;
      SCC_PIN_INT_FAST: pin_lvl = int_fast_osc_i;
      SCC_PIN_EXT_FAST: pin_lvl = ext_fast_osc_i;
    endcase
  end

  scc_clk_div u_pin_div (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .src_i(pin_lvl),
    .code_i(pin_cfg[SCC_PIN_DIV_LSB +: 3]),
    .clk_o(pin_div)
  );

  // ==========================================================
  // registers, switch sequencer, supervisor and interrupt status
  always_comb
  begin
    next_st = st;
    next_sys_tgt = sys_tgt;
    next_sys_cur = sys_cur;
    next_div_code = div_code;
    next_gate = gate;
    next_periph = periph;
    next_rtc_src = rtc_src;
    next_sv_en = sv_en;
    next_sv_fail = sv_fail;
    next_pin_cfg = pin_cfg;
    next_osc_cfg = osc_cfg;
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    next_rdata = '0;
    next_mux = mux_q;
    // software writes; source change refused while a switch runs
    if (reg_we_i)
    begin
      unique case (reg_addr_i)
        SCC_REG_SYS_SRC: if (st == SCC_SW_IDLE && sys_tgt == sys_cur) next_sys_tgt = reg_wdata_i[1:0];
        SCC_REG_SYS_DIV: next_div_code = reg_wdata_i[2:0];
        SCC_REG_GATE: next_gate = reg_wdata_i[1:0];
        SCC_REG_PERIPH: next_periph = reg_wdata_i[NP-1:0];
        SCC_REG_RTC_SRC: next_rtc_src = reg_wdata_i[1:0];
        SCC_REG_SUPERV:
        begin
          next_sv_en = reg_wdata_i[SCC_SV_EN];
          // disabling supervision is the only way to drop the flag
          if (!reg_wdata_i[SCC_SV_EN])
            next_sv_fail = 1'b0;
        end
        SCC_REG_PIN_OUT: next_pin_cfg = reg_wdata_i[5:0];
        SCC_REG_OSC_CFG: next_osc_cfg = reg_wdata_i[3:0];
        SCC_REG_IRQ_MASK: next_irq_mask = reg_wdata_i[1:0];
        default: ;
      endcase
    end
    // software reads; unmapped reads return zero
    if (reg_re_i)
    begin
      unique case (reg_addr_i)
        SCC_REG_SYS_SRC: next_rdata = SCC_DW'(sys_tgt);
        SCC_REG_SYS_DIV: next_rdata = SCC_DW'(div_code);
        SCC_REG_GATE: next_rdata = SCC_DW'(gate);
        SCC_REG_PERIPH: next_rdata = SCC_DW'(periph);
        SCC_REG_RTC_SRC: next_rdata = SCC_DW'(rtc_src);
        SCC_REG_SUPERV: next_rdata = SCC_DW'({sv_fail, sv_en});
        SCC_REG_PIN_OUT: next_rdata = SCC_DW'(pin_cfg);
        SCC_REG_OSC_CFG: next_rdata = SCC_DW'(osc_cfg);
        SCC_REG_IRQ_STAT:
        begin
          next_rdata = SCC_DW'(irq_stat);
          next_irq_stat = 2'h0; // read clears; new events below win
        end
        SCC_REG_IRQ_MASK: next_rdata = SCC_DW'(irq_mask);
        SCC_REG_SW_STAT: next_rdata = SCC_DW'({st != SCC_SW_IDLE, sys_cur});
        default: next_rdata = '0;
      endcase
    end
    // glitch-free switch: park old source low, then wait for new low
    unique case (st)
      SCC_SW_IDLE:
      begin
        next_mux = osc_lvl[sys_cur];
        if (sys_tgt != sys_cur)
          next_st = SCC_SW_OLD_LOW;
      end
      SCC_SW_OLD_LOW:
      begin
        next_mux = osc_lvl[sys_cur];
        if (!osc_lvl[sys_cur])
        begin
          next_st = SCC_SW_NEW_LOW;
          next_mux = 1'b0;
        end
      end
      SCC_SW_NEW_LOW:
      begin
        next_mux = 1'b0; // held low, no runt pulse either side
        if (!osc_lvl[sys_tgt])
        begin
          next_sys_cur = sys_tgt;
          next_st = SCC_SW_IDLE;
          next_irq_stat[SCC_IRQ_SWITCH] = 1'b1;
        end
      end
    endcase
    // dead clock never goes low, so skip the old-low wait
    if (fail_evt)
    begin
      next_sys_tgt = SCC_SRC_INT_FAST;
      next_st = SCC_SW_NEW_LOW;
      next_mux = 1'b0;
      next_sv_fail = 1'b1;
      next_irq_stat[SCC_IRQ_FAIL] = 1'b1;
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      st <= SCC_SW_IDLE;
      sys_tgt <= SCC_RST_SYS_SRC;
      sys_cur <= SCC_RST_SYS_SRC;
      div_code <= SCC_RST_SYS_DIV;
      gate <= SCC_RST_GATE;
      periph <= SCC_RST_PERIPH[NP-1:0];
      rtc_src <= SCC_RST_RTC_SRC;
      sv_en <= 1'b0;
      sv_fail <= 1'b0;
      pin_cfg <= SCC_RST_PIN_OUT;
      osc_cfg <= SCC_RST_OSC_CFG;
      irq_stat <= 2'h0;
      irq_mask <= SCC_RST_IRQ_MASK;
      reg_rdata_o <= '0;
      irq_o <= 1'b0;
      mux_q <= 1'b0;
    end
    else
    begin
      st <= next_st;
      sys_tgt <= next_sys_tgt;
      sys_cur <= next_sys_cur;
      div_code <= next_div_code;
      gate <= next_gate;
      periph <= next_periph;
      rtc_src <= next_rtc_src;
      sv_en <= next_sv_en;
      sv_fail <= next_sv_fail;
      pin_cfg <= next_pin_cfg;
      osc_cfg <= next_osc_cfg;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      reg_rdata_o <= next_rdata;
      irq_o <= next_irq;
      mux_q <= next_mux;
    end
  end

  // ==========================================================
  // gate enables: only change while the divided clock is low,
  // so a gate never chops a high phase
  always_comb
  begin
    next_core_en = core_en;
    next_mem_en = mem_en;
    next_per_en = per_en;
    if (!sys_div)
    begin
      next_core_en = gate[SCC_GATE_CORE] && !wait_mode_i && !active_halt_i;
      next_mem_en = gate[SCC_GATE_MEM] && !active_halt_i;
      next_per_en = periph & {NP{!active_halt_i}};
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      core_en <= 1'b0;
      mem_en <= 1'b0;
      per_en <= '0;
    end
    else
    begin
      core_en <= next_core_en;
      mem_en <= next_mem_en;
      per_en <= next_per_en;
    end
  end

  // ==========================================================
  // clock and oscillator outputs, all registered
  // rtc mux switches raw: a runt pulse is possible on a change
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      main_system_clock_o <= 1'b0;
      core_clk_o <= 1'b0;
      mem_clk_o <= 1'b0;
      periph_clk_o <= '0;
      rtc_clk_o <= 1'b0;
      clock_pin_output_o <= 1'b0;
      ext_fast_osc_en_o <= 1'b0;
      ext_fast_osc_bypass_o <= 1'b0;
      ext_slow_osc_en_o <= 1'b0;
      ext_slow_osc_bypass_o <= 1'b0;
    end
    else
    begin
      main_system_clock_o <= sys_div;
      core_clk_o <= sys_div && core_en;
      mem_clk_o <= sys_div && mem_en;
      periph_clk_o <= {NP{sys_div}} & per_en;
      rtc_clk_o <= osc_lvl[rtc_src];
      clock_pin_output_o <= pin_cfg[SCC_PIN_EN] && pin_div;
      // an oscillator the system or rtc clock uses is held on whatever software wrote
      ext_fast_osc_en_o <= osc_cfg[SCC_OSC_EF_EN] || sys_cur == SCC_SRC_EXT_FAST
        || sys_tgt == SCC_SRC_EXT_FAST || rtc_src == SCC_SRC_EXT_FAST;
      ext_fast_osc_bypass_o <= osc_cfg[SCC_OSC_EF_BYP];
      ext_slow_osc_en_o <= osc_cfg[SCC_OSC_ES_EN] || sys_cur == SCC_SRC_EXT_SLOW
        || sys_tgt == SCC_SRC_EXT_SLOW || rtc_src == SCC_SRC_EXT_SLOW;
      ext_slow_osc_bypass_o <= osc_cfg[SCC_OSC_ES_BYP];
    end
  end

endmodule // scc_clock_ctrl

// [scc_osc_model.sv]
// scc_osc_model: the four oscillator levels.
// assumes levels change just after a rising clock_i.

`timescale 1ns/1ps

module scc_osc_model (
  // clock and oscillator control
  input wire logic clock_i,
  input wire logic ext_fast_en_i,
  input wire logic ext_fast_stop_i,
  input wire logic ext_slow_en_i,
  // oscillator levels
  output logic ext_fast_osc_o = 1'b0,
  output logic int_fast_osc_o = 1'b0,
  output logic ext_slow_osc_o = 1'b0,
  output logic int_slow_osc_o = 1'b0
);
  int cnt = 0;

  // ==========================================================
  // half periods 2, 3, 10 and 13 cycles; an external one halts while disabled
  always @(posedge clock_i)
  begin
    cnt <= cnt + 1;
    if (cnt % 2 == 1)
      int_fast_osc_o <= ~int_fast_osc_o;
    if (cnt % 3 == 2 && ext_fast_en_i && !ext_fast_stop_i)
      ext_fast_osc_o <= ~ext_fast_osc_o; // stop models a dead crystal
    if (cnt % 10 == 9 && ext_slow_en_i)
      ext_slow_osc_o <= ~ext_slow_osc_o;
    if (cnt % 13 == 12)
      int_slow_osc_o <= ~int_slow_osc_o;
  end
endmodule // scc_osc_model

// [scc_clock_ctrl_assertions.sv]
// scc_clock_ctrl_assertions: port checks of the clock controller.
// assumes one clock and the active-low reset.

`timescale 1ns/1ps

module scc_clock_ctrl_checker
  import scc_pkg::*;
#(
  parameter int NP = 8
)(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [SCC_AW-1:0] reg_addr_i,
  input wire logic [SCC_DW-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [SCC_DW-1:0] reg_rdata_o,
  // oscillator control
  input wire logic ext_fast_osc_en_o,
  input wire logic ext_fast_osc_bypass_o,
  input wire logic ext_slow_osc_bypass_o,
  // power states and clocks
  input wire logic wait_mode_i,
  input wire logic active_halt_i,
  input wire logic main_system_clock_o,
  input wire logic core_clk_o,
  input wire logic mem_clk_o,
  input wire logic [NP-1:0] periph_clk_o,
  input wire logic irq_o
);
  default clocking cb_main @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // ==========================================================
  // register writes that start a check
  sequence s_osc_wr;
    reg_we_i && reg_addr_i == SCC_REG_OSC_CFG;
  endsequence
  sequence s_core_off;
    reg_we_i && reg_addr_i == SCC_REG_GATE && !reg_wdata_i[SCC_GATE_CORE];
  endsequence
  sequence s_periph_off;
    reg_we_i && reg_addr_i == SCC_REG_PERIPH && !reg_wdata_i[1];
  endsequence

  // ==========================================================
  // properties; 4 cycles of a power state let the low-phase gate update
  property p_reset_quiet;
    $rose(rst_b_i) |-> !main_system_clock_o && !core_clk_o && !irq_o && reg_rdata_o == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("clocks not quiet after reset");
  property p_rdata_idle;
    !$past(reg_re_i) |-> reg_rdata_o == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
  property p_wait_core;
    wait_mode_i[*4] |-> !$rose(core_clk_o);
  endproperty
  a_wait_core: assert property (p_wait_core) else $error("core clock runs in wait");
  property p_halt_stop;
    active_halt_i[*4] |-> !$rose(core_clk_o) && !$rose(mem_clk_o) && !$rose(periph_clk_o[0]);
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("clock runs in active halt");
  property p_core_gate;
    s_core_off |-> ##3 (!$rose(core_clk_o))[*8];
  endproperty
  a_core_gate: assert property (p_core_gate) else $error("gated core clock rose");
  property p_periph_gate;
    s_periph_off |-> ##3 (!$rose(periph_clk_o[1]))[*8];
  endproperty
  a_periph_gate: assert property (p_periph_gate) else $error("gated peripheral clock rose");
  property p_bypass;
    s_osc_wr |-> ##2 ext_fast_osc_bypass_o == $past(reg_wdata_i[SCC_OSC_EF_BYP], 2)
      && ext_slow_osc_bypass_o == $past(reg_wdata_i[SCC_OSC_ES_BYP], 2);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass outputs differ from setting");
  property p_fast_en;
    s_osc_wr ##0 reg_wdata_i[SCC_OSC_EF_EN] |-> ##2 ext_fast_osc_en_o;
  endproperty
  a_fast_en: assert property (p_fast_en) else $error("fast oscillator not enabled");
endmodule // scc_clock_ctrl_checker

bind scc_clock_ctrl scc_clock_ctrl_checker #(.NP(NP)) chk_u (.*);

// [test_scc_clock_ctrl.sv]
// test_scc_clock_ctrl: self-checking bench of the clock controller.
// assumes package, design, model and checker compiled first.

`timescale 1ns/1ps

module test_scc_clock_ctrl
  import scc_pkg::*;
;
  logic clock_i, rst_b_i, reg_we_i, reg_re_i, wait_mode_i, active_halt_i, osc_stop, watch;
  logic [SCC_AW-1:0] reg_addr_i;
  logic [SCC_DW-1:0] reg_wdata_i, reg_rdata_o;
  logic ext_fast_osc_i, int_fast_osc_i, ext_slow_osc_i, int_slow_osc_i;
  logic ext_fast_osc_en_o, ext_fast_osc_bypass_o, ext_slow_osc_en_o, ext_slow_osc_bypass_o;
  logic main_system_clock_o, core_clk_o, mem_clk_o, rtc_clk_o, clock_pin_output_o, irq_o;
  logic [7:0] periph_clk_o;
  logic [6:0] taps;
  logic last_main = 1'b0;
  logic short_seen = 1'b0;
  int fails = 0;
  int checks = 0;
  int run = 2;
  localparam int SRCP [4] = '{4, 6, 20, 26};
  localparam int PINP [5] = '{4, 26, 4, 6, 8};
  localparam logic [7:0] PINW [5] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0e};
  localparam logic [7:0] RSTV [16] = '{1: 8'h03, 2: 8'h03, 3: 8'hff, 4: 8'h03, default: 8'h00};

  scc_clock_ctrl #(.NP(8), .FAIL_TIMEOUT_CYC(20)) dut_u (.*);
  assign taps = {periph_clk_o[1:0], mem_clk_o, core_clk_o, clock_pin_output_o, rtc_clk_o, main_system_clock_o};
  scc_osc_model osc_u (.clock_i, .ext_fast_en_i(ext_fast_osc_en_o), .ext_fast_stop_i(osc_stop),
    .ext_slow_en_i(ext_slow_osc_en_o), .ext_fast_osc_o(ext_fast_osc_i), .int_fast_osc_o(int_fast_osc_i),
    .ext_slow_osc_o(ext_slow_osc_i), .int_slow_osc_o(int_slow_osc_i));

  // ==========================================================
  // clock and runt-pulse watch
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    run <= (main_system_clock_o != last_main) ? 1 : run + 1;
    last_main <= main_system_clock_o;
    if (watch && main_system_clock_o != last_main && run < 2)
      short_seen <= 1'b1;
  end

  // ==========================================================
  // bus and measuring helpers
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask
  task tmo(input string what);
    chk(what, 1, 0);
    report_and_stop;
  endtask
  // trailing idle edge keeps a strobe from being set twice in one step
  task wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clock_i);
    reg_we_i <= 1'b0;
    @(posedge clock_i);
  endtask
  // data sampled mid-cycle, while it stands
  task rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clock_i);
    reg_re_i <= 1'b0;
    @(negedge clock_i);
    d = reg_rdata_o;
    @(posedge clock_i);
  endtask
  // one full period of an output, after a settling one
  task period(input int s, output int p);
    logic last;
    int n;
    last = taps[s];
    n = 0;
    p = 0;
    for (int t = 0; n < 3; t++)
    begin
      @(posedge clock_i);
      if (taps[s] && !last)
        n++;
      if (n == 2)
        p++;
      last = taps[s];
      if (t > 3000)
        tmo("clock edge");
    end
  endtask
  task act(input int s, input logic on);
    logic last;
    int e;
    repeat (4) @(posedge clock_i);
    last = taps[s];
    e = 0;
    repeat (100)
    begin
      @(posedge clock_i);
      if (taps[s] && !last)
        e++;
      last = taps[s];
    end
    chk("clock activity", on, e > 0);
  endtask
  task poll_src(input logic [1:0] s);
    logic [7:0] d;
    int n;
    d = 8'hff;
    n = 0;
    while (d[2:0] !== {1'b0, s})
    begin
      rd(SCC_REG_SW_STAT, d);
      n++;
      if (n > 1000)
        tmo("source switch");
    end
    chk("current source", s, d[1:0]);
  endtask

  // ==========================================================
  // scenarios
  task t_reset;
    logic [7:0] d;
    int p;
    for (int a = 0; a < 16; a++)
    begin
      rd(4'(a), d);
      chk("reset value", RSTV[a], d);
    end
    period(0, p);
    chk("start period", 32, p);
    $display("reset test done");
  endtask
  task t_div;
    int p;
    for (int c = 0; c < 4; c++)
    begin
      wr(SCC_REG_SYS_DIV, 8'(c));
      period(0, p);
      chk("divided period", 4 << c, p);
    end
    wr(SCC_REG_SYS_DIV, 8'h00);
    $display("divider test done");
  endtask
  task t_src;
    logic [7:0] d;
    logic [1:0] s;
    int p;
    wr(SCC_REG_OSC_CFG, 8'h05);
    watch <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      s = 2'(i + 1);
      wr(SCC_REG_IRQ_MASK, (i == 0) ? 8'h00 : 8'h02);
      reg_addr_i <= SCC_REG_SYS_SRC;
      reg_wdata_i <= {6'h00, s};
      reg_we_i <= 1'b1;
      @(posedge clock_i);
      reg_wdata_i <= 8'h00; // back-to-back write refused while pending
      reg_we_i <= (s == SCC_SRC_INT_SLOW);
      @(posedge clock_i);
      reg_we_i <= 1'b0;
      poll_src(s);
      chk("switch irq", i != 0, irq_o);
      rd(SCC_REG_IRQ_STAT, d);
      chk("switch status", 8'h02, d);
      @(posedge clock_i);
      chk("irq after clear", 1'b0, irq_o);
      period(0, p);
      chk("system period", SRCP[s], p);
    end
    watch <= 1'b0;
    chk("short pulse", 1'b0, short_seen);
    $display("source test done");
  endtask
  task t_rtc;
    logic [7:0] d;
    int p;
    for (int r = 0; r < 4; r++)
    begin
      wr(SCC_REG_RTC_SRC, 8'(r));
      period(1, p);
      chk("rtc period", SRCP[r], p);
      rd(SCC_REG_SW_STAT, d);
      chk("system source kept", 8'h00, d);
    end
    $display("rtc test done");
  endtask
  task t_gate;
    wr(SCC_REG_GATE, 8'h00);
    act(3, 1'b0);
    act(4, 1'b0);
    wr(SCC_REG_GATE, 8'h03);
    wr(SCC_REG_PERIPH, 8'h01);
    act(3, 1'b1);
    act(5, 1'b1);
    act(6, 1'b0);
    wait_mode_i <= 1'b1;
    act(3, 1'b0);
    act(5, 1'b1);
    wait_mode_i <= 1'b0;
    active_halt_i <= 1'b1;
    act(3, 1'b0);
    act(4, 1'b0);
    act(5, 1'b0);
    act(1, 1'b1);
    active_halt_i <= 1'b0;
    $display("gating test done");
  endtask
  task t_pin;
    int p;
    for (int k = 0; k < 5; k++)
    begin
      wr(SCC_REG_PIN_OUT, PINW[k]);
      period(2, p);
      chk("pin period", PINP[k], p);
    end
    wr(SCC_REG_PIN_OUT, 8'h02);
    act(2, 1'b0);
    $display("pin test done");
  endtask
  task t_fail;
    logic [7:0] d;
    wr(SCC_REG_SUPERV, 8'h01);
    wr(SCC_REG_IRQ_MASK, 8'h01);
    wr(SCC_REG_SYS_SRC, 8'h01);
    poll_src(SCC_SRC_EXT_FAST);
    osc_stop <= 1'b1;
    poll_src(SCC_SRC_INT_FAST);
    rd(SCC_REG_SUPERV, d);
    chk("failure flag", 8'h03, d);
    chk("failure irq", 1'b1, irq_o);
    rd(SCC_REG_IRQ_STAT, d);
    chk("failure status", 1'b1, d[SCC_IRQ_FAIL]);
    wr(SCC_REG_SUPERV, 8'h00);
    rd(SCC_REG_SUPERV, d);
    chk("flag cleared", 8'h00, d);
    wr(SCC_REG_OSC_CFG, 8'h0f);
    repeat (2) @(posedge clock_i);
    chk("fast bypass", 1'b1, ext_fast_osc_bypass_o);
    chk("slow bypass", 1'b1, ext_slow_osc_bypass_o);
    $display("failure test done");
  endtask

  // ==========================================================
  // main sequence; reset held four cycles
  initial
  begin
    rst_b_i = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    wait_mode_i = 1'b0;
    active_halt_i = 1'b0;
    osc_stop = 1'b0;
    watch = 1'b0;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    t_reset;
    t_div;
    t_src;
    t_rtc;
    t_gate;
    t_pin;
    t_fail;
    report_and_stop;
  end
endmodule // test_scc_clock_ctrl
